// File: core/dps_host.sv
// Controller driving one port's semaphore pins of a dual-port static RAM
`timescale 1ns/1ps

module dps_host (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_cmd_valid,
   input wire dps_pkg::dps_op_t i_cmd_op,
   input wire logic [dps_pkg::IDX_W-1:0] i_cmd_idx,
   input wire logic i_cmd_retry,
   input wire logic i_abort,
   output logic o_cmd_ready,
   output logic o_done,
   output logic o_granted,
   output logic o_ce_n,
   output logic o_token_space_select_n,
   output logic o_oe_n,
   output logic o_rw_n,
   output logic [dps_pkg::ADDR_W-1:0] o_addr,
   input wire logic [dps_pkg::DATA_W-1:0] i_dq,
   output logic [dps_pkg::DATA_W-1:0] o_dq,
   output logic o_dq_oe
);
   import dps_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   dps_state_t state_r, state_nxt;
   dps_op_t op_r, op_nxt;
   logic [IDX_W-1:0] idx_r, idx_nxt;
   logic wval_r, wval_nxt;
   logic retry_r, retry_nxt;
   logic boot_r;
   logic got_r;
   logic [3:0] cnt_r;
   logic [DATA_W-1:0] dq_sync;
   logic timer_done;

   dps_sync #(.W(DATA_W)) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_d(i_dq),
      .o_q(dq_sync)
   );

   assign timer_done = (cnt_r == 4'h0);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      op_nxt = op_r;
      idx_nxt = idx_r;
      wval_nxt = wval_r;
      retry_nxt = retry_r;
      case (state_r)
         DPS_IDLE: begin
            if (boot_r) begin
               op_nxt = DPS_OP_INIT;
               idx_nxt = 3'h0;
               wval_nxt = 1'b1;
               retry_nxt = 1'b0;
               state_nxt = DPS_WSET;
            end else if (i_cmd_valid) begin
               op_nxt = i_cmd_op;
               idx_nxt = (i_cmd_op == DPS_OP_INIT) ? 3'h0 : i_cmd_idx;
               wval_nxt = (i_cmd_op != DPS_OP_CLAIM);
               retry_nxt = i_cmd_retry;
               state_nxt = (i_cmd_op == DPS_OP_NONE) ? DPS_DONE : DPS_WSET;
            end
         end
         DPS_WSET: begin
            if (timer_done) begin
               state_nxt = DPS_WPULSE;
            end
         end
         DPS_WPULSE: begin
            if (timer_done) begin
               state_nxt = DPS_WGAP;
            end
         end
         DPS_WGAP: begin
            if (timer_done) begin
               if (op_r == DPS_OP_INIT && idx_r != LAST_IDX) begin
                  idx_nxt = idx_r + 3'h1;
                  state_nxt = DPS_WSET;
               end else if (op_r == DPS_OP_CLAIM && !wval_r) begin
                  state_nxt = DPS_RSET;
               end else begin
                  state_nxt = DPS_DONE;
               end
            end
         end
         DPS_RSET: begin
            if (timer_done) begin
               state_nxt = DPS_RACC;
            end
         end
         DPS_RACC: begin
            if (timer_done) begin
               state_nxt = DPS_RGAP;
            end
         end
         DPS_RGAP: begin
            if (timer_done) begin
               if (got_r) begin
                  state_nxt = DPS_DONE;
               end else if (i_abort || !retry_r) begin
                  // A standing request would hand us the token later
                  wval_nxt = 1'b1;
                  state_nxt = DPS_WSET;
               end else begin
                  state_nxt = DPS_RSET;
               end
            end
         end
         DPS_DONE: begin
            state_nxt = DPS_IDLE;
         end
         default: begin
            state_nxt = DPS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= DPS_IDLE;
         op_r <= DPS_OP_NONE;
         idx_r <= 3'h0;
         wval_r <= 1'b1;
         retry_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         idx_r <= idx_nxt;
         wval_r <= wval_nxt;
         retry_r <= retry_nxt;
      end
   end

   // Start-up sweep runs once per reset
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         boot_r <= 1'b1;
      end else if (state_r == DPS_IDLE) begin
         boot_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Phase timer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= 4'h0;
      end else if (state_nxt != state_r) begin
         case (state_nxt)
            DPS_WSET: cnt_r <= SETUP_CYC - 4'h1;
            DPS_RSET: cnt_r <= SETUP_CYC - 4'h1;
            DPS_WPULSE: cnt_r <= WPULSE_CYC - 4'h1;
            DPS_RACC: cnt_r <= RACC_CYC - 4'h1;
            DPS_WGAP: cnt_r <= GAP_CYC - 4'h1;
            DPS_RGAP: cnt_r <= GAP_CYC - 4'h1;
            default: cnt_r <= 4'h0;
         endcase
      end else if (!timer_done) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // Read capture
   // ----------------------------------------------------------------
   // Sampled at the end of the access window, before output enable drops
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         got_r <= 1'b0;
      end else if (state_r == DPS_WSET) begin
         got_r <= 1'b0;
      end else if (state_r == DPS_RACC && timer_done) begin
         got_r <= ~dq_sync[0];
      end
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ce_n <= 1'b1;
         o_token_space_select_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_rw_n <= 1'b1;
         o_addr <= 14'h0000;
         o_dq <= 16'h0000;
         o_dq_oe <= 1'b0;
      end else begin
         o_ce_n <= 1'b1;
         // Select drops in every gap so the device's read latch refreshes
         o_token_space_select_n <= !(state_nxt == DPS_WSET || state_nxt == DPS_WPULSE ||
                                     state_nxt == DPS_RSET || state_nxt == DPS_RACC);
         o_oe_n <= !(state_nxt == DPS_RACC);
         o_rw_n <= !(state_nxt == DPS_WPULSE);
         o_addr <= {11'h000, idx_nxt};
         o_dq <= {DATA_W{wval_nxt}};
         o_dq_oe <= (state_nxt == DPS_WPULSE);
      end
   end

   // ----------------------------------------------------------------
   // User side
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cmd_ready <= 1'b0;
         o_done <= 1'b0;
         o_granted <= 1'b0;
      end else begin
         o_cmd_ready <= (state_nxt == DPS_IDLE) && !(boot_r && state_r != DPS_IDLE);
         o_done <= (state_nxt == DPS_DONE);
         if (state_nxt == DPS_DONE) begin
            // Next op, so a no-op straight after a won claim cannot repeat the old grant
            o_granted <= (op_nxt == DPS_OP_CLAIM) && got_r;
         end
      end
   end
endmodule

// File: core/dps_sync.sv
// Package of shared constants and the input synchroniser for the semaphore port controller
`timescale 1ns/1ps

package dps_pkg;
   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int NUM_TOKENS = 8;
   localparam int IDX_W = 3;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 16;
   localparam logic [IDX_W-1:0] LAST_IDX = 3'h7;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_SETUP_NS = 20;
   localparam int T_WPULSE_NS = 40;
   localparam int T_RACC_NS = 60;
   localparam int T_GAP_NS = 20;
   // Least times, rounded up to whole cycles
   localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] WPULSE_CYC = 4'((T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] RACC_CYC = 4'((T_RACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] GAP_CYC = 4'((T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // Commands and states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DPS_OP_CLAIM = 2'b00,
      DPS_OP_RELEASE = 2'b01,
      DPS_OP_INIT = 2'b10,
      DPS_OP_NONE = 2'b11
   } dps_op_t;

   typedef enum logic [2:0] {
      DPS_IDLE = 3'b000,
      DPS_WSET = 3'b001,
      DPS_WPULSE = 3'b010,
      DPS_WGAP = 3'b011,
      DPS_RSET = 3'b100,
      DPS_RACC = 3'b101,
      DPS_RGAP = 3'b110,
      DPS_DONE = 3'b111
   } dps_state_t;
endpackage

module dps_sync #(
   parameter int W = 16
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_r;

   // Two stages; the first is read by the second only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r <= '0;
         o_q <= '0;
      end else begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end
endmodule

// File: tb/dps_host_chk.sv
// Checker on the pins of the semaphore port controller
`timescale 1ns/1ps
module dps_host_chk (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_cmd_valid,
   input wire dps_pkg::dps_op_t i_cmd_op,
   input wire logic o_cmd_ready,
   input wire logic o_done,
   input wire logic o_ce_n,
   input wire logic o_token_space_select_n,
   input wire logic o_oe_n,
   input wire logic o_rw_n,
   input wire logic [dps_pkg::ADDR_W-1:0] o_addr,
   input wire logic [dps_pkg::DATA_W-1:0] o_dq,
   input wire logic o_dq_oe
);
   import dps_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   ce_held_a: assert property (o_ce_n) else $error("memory enable dropped");
   addr_high_a: assert property (o_addr[13:3] == 11'h000) else $error("high address set");
   data_spread_a: assert property (o_dq_oe |-> o_dq == 16'h0000 || o_dq == 16'hffff)
      else $error("write data bits differ");
   drive_write_a: assert property (o_dq_oe == !o_rw_n) else $error("data drive outside pulse");
   pulse_len_a: assert property ($fell(o_rw_n) |-> !o_rw_n [*4] ##1 o_rw_n)
      else $error("write pulse length wrong");
   poll_gap_a: assert property ($rose(o_token_space_select_n) |-> o_token_space_select_n [*2])
      else $error("select gap too short");
   write_first_a: assert property (i_cmd_valid && o_cmd_ready && i_cmd_op == DPS_OP_CLAIM |=> o_oe_n [*8])
      else $error("claim read before write");
   start_sweep_a: assert property ($rose(i_rst_n) |-> ##[1:100] o_done)
      else $error("start-up sweep missing");
endmodule

bind dps_host dps_host_chk chk_u (.i_clk, .i_rst_n, .i_cmd_valid, .i_cmd_op, .o_cmd_ready, .o_done, .o_ce_n,
   .o_token_space_select_n, .o_oe_n, .o_rw_n, .o_addr, .o_dq, .o_dq_oe);

// File: tb/dps_host_tb_top.sv
// Self-checking bench for the semaphore port controller
`timescale 1ns/1ps
module dps_host_tb_top;
   import dps_pkg::*;
   logic clk = 0, rst_n = 0, vld = 0, retry = 0, abort_r = 0, h, q;
   dps_op_t op = DPS_OP_NONE;
   logic [2:0] idx = 3'h0, b_idx = 3'h0, ti;
   logic b_sel_n = 1, b_oe_n = 1, b_rw_n = 1, b_d0 = 1;
   logic rdy, done, gnt, ce_n, sel_n, oe_n, rw_n, dq_oe;
   logic [13:0] addr;
   logic [15:0] dq_o, dq;
   logic [31:0] mq, seed = 32'he695_ca70;
   int n_fail = 0, cmp_count = 0;
   always #5 clk = ~clk;
   assign dq = dq_oe ? dq_o : mq[15:0];
   dps_host dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(vld), .i_cmd_op(op), .i_cmd_idx(idx),
      .i_cmd_retry(retry), .i_abort(abort_r), .o_cmd_ready(rdy), .o_done(done), .o_granted(gnt),
      .o_ce_n(ce_n), .o_token_space_select_n(sel_n), .o_oe_n(oe_n), .o_rw_n(rw_n), .o_addr(addr),
      .i_dq(dq), .o_dq(dq_o), .o_dq_oe(dq_oe));
   // Write bit taken from the driver itself; the bus mux flips in the same step as the strobe
   dps_sem_model dev_u (.i_sel_n({b_sel_n, sel_n}), .i_oe_n({b_oe_n, oe_n}), .i_rw_n({b_rw_n, rw_n}),
      .i_idx({b_idx, addr[2:0]}), .i_d0({b_d0, dq_o[0]}), .o_q(mq));
   task automatic chk(input logic seen, input logic exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %b seen %b", what, exp, seen);
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Far-side processor: write when wr is set, else read with the flag into q
   task automatic b_acc(input logic [2:0] i, input logic wr, input logic v);
      @(posedge clk);
      b_sel_n <= 0;
      b_idx <= i;
      b_d0 <= v;
      repeat (2) @(posedge clk);
      b_rw_n <= !wr;
      b_oe_n <= wr;
      repeat (6) @(posedge clk);
      q = mq[16];
      b_sel_n <= 1;
      b_oe_n <= 1;
      b_rw_n <= 1;
      repeat (2) @(posedge clk);
   endtask
   task automatic b_claim(input logic [2:0] i);
      b_acc(i, 1, 0);
      b_acc(i, 0, 0);
   endtask
   task automatic all_free;
      for (int i = 0; i < 8; i++) begin
         b_claim(3'(i));
         chk(q, 0, "token free");
         b_acc(3'(i), 1, 1);
      end
   endtask
   task automatic cmd(input dps_op_t o, input logic [2:0] i, input logic r);
      int n = 0;
      @(negedge clk);
      while (rdy !== 1) @(negedge clk);
      @(posedge clk);
      vld <= 1;
      op <= o;
      idx <= i;
      retry <= r;
      @(posedge clk);
      vld <= 0;
      while (done !== 1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      chk(done, 1, "command done");
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      print_verdict();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1;
      cmd(DPS_OP_NONE, 3'h0, 0);
      chk(gnt, 0, "no-op grant");
      all_free();
      $display("test startup done");
      for (int k = 0; k < 12; k++) begin
         seed = lfsr(seed);
         h = seed[5];
         ti = seed[2:0];
         if (h) b_claim(ti);
         cmd(DPS_OP_CLAIM, ti, 0);
         chk(gnt, !h, "claim grant");
         if (!h) begin
            cmd(DPS_OP_NONE, ti, 0);
            chk(gnt, 0, "no-op after grant");
            b_claim(ti);
            chk(q, 1, "held elsewhere");
            b_acc(ti, 1, 1);
            cmd(DPS_OP_RELEASE, ti, 0);
         end else b_acc(ti, 1, 1);
         b_claim(ti);
         chk(q, 0, "freed token");
         b_acc(ti, 1, 1);
      end
      $display("test random done");
      // Polling claim, once won on release and once cut short
      for (int ab = 0; ab < 2; ab++) begin
         b_claim(3'h3);
         fork
            cmd(DPS_OP_CLAIM, 3'h3, 1);
            begin
               repeat (80) @(posedge clk);
               if (ab == 1) abort_r <= 1;
               else b_acc(3'h3, 1, 1);
            end
         join
         @(posedge clk);
         abort_r <= 0;
         chk(gnt, ab == 0, "poll grant");
         if (ab == 1) b_acc(3'h3, 1, 1);
         else cmd(DPS_OP_RELEASE, 3'h3, 0);
         b_claim(3'h3);
         chk(q, 0, "after poll");
         b_acc(3'h3, 1, 1);
      end
      $display("test poll done");
      cmd(DPS_OP_CLAIM, 3'h6, 0);
      cmd(DPS_OP_INIT, 3'h0, 0);
      chk(gnt, 0, "sweep grant");
      all_free();
      $display("test sweep done");
      print_verdict();
   end
endmodule

// File: tb/dps_sem_model.sv
// Behavioural two-port semaphore device; port 0 faces the controller
`timescale 1ns/1ps
module dps_sem_model (
   input wire logic [1:0] i_sel_n,
   input wire logic [1:0] i_oe_n,
   input wire logic [1:0] i_rw_n,
   input wire logic [5:0] i_idx,
   input wire logic [1:0] i_d0,
   output logic [31:0] o_q
);
   logic [7:0] req_n [2];
   logic [1:0] own [8];
   logic [1:0] hold;
   // Not cleared at power-up: port 0 starts owning every token
   initial begin
      req_n[0] = 8'h00;
      req_n[1] = 8'hff;
      hold = 2'b00;
      for (int i = 0; i < 8; i++) own[i] = 2'h1;
   end
   for (genvar p = 0; p < 2; p++) begin : g_port
      localparam logic [1:0] ME = 2'(p + 1);
      logic wr_n;
      logic rd_n;
      logic [2:0] ix;
      assign wr_n = i_sel_n[p] | i_rw_n[p];
      assign rd_n = i_sel_n[p] | i_oe_n[p];
      assign ix = i_idx[3*p +: 3];
      // Acts as the pulse opens; a tie falls to whichever event runs first
      always @(negedge wr_n) begin
         req_n[p][ix] = i_d0[p];
         if (own[ix] == ME && i_d0[p]) own[ix] = req_n[1-p][ix] ? 2'h0 : 2'h3 - ME;
         else if (own[ix] == 2'h0 && !i_d0[p]) own[ix] = ME;
      end
      always @(negedge rd_n) hold[p] = (own[ix] != ME);
      // Released lines show the inverse so a stale read cannot pass
      assign o_q[16*p +: 16] = {16{rd_n ^ hold[p]}};
   end
endmodule
